// [hdl/dmr_atten_ramp.sv]
/*
 one channel of the stepping digital attenuator.
 assumes a one-cycle step tick every eight sample periods.
*/
`timescale 1ns/10ps
`default_nettype none
module dmr_atten_ramp
    import dmr_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic step_tick,
    input wire logic [7:0] atten_code,
    input wire logic soft_mute,
    input wire logic atten_mode_sel,
    output logic [7:0] applied_code,
    output logic [8:0] atten_halfdb,
    output logic muted
);
    logic [7:0] cur_r, cur_nxt, floor_code, target;
    logic [8:0] halfdb_r, halfdb_nxt;
    logic muted_r, muted_nxt;
    logic [7:0] below;

    always_comb begin
        floor_code = atten_mode_sel ? ATTEN_FLOOR_WIDE : ATTEN_FLOOR_FINE;
        if (soft_mute || atten_code <= floor_code) begin
            target = floor_code;
        end else begin
            target = atten_code;
        end
        cur_nxt = cur_r;
        if (step_tick && cur_r < target) begin
            cur_nxt = cur_r + 8'h01;
        end else if (step_tick && cur_r > target) begin
            cur_nxt = cur_r - 8'h01;
        end
        below = ATTEN_RST - cur_nxt;
        halfdb_nxt = atten_mode_sel ? {below, 1'b0} : {1'b0, below};
        muted_nxt = cur_nxt <= floor_code;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cur_r <= ATTEN_RST;
            halfdb_r <= 9'h000;
            muted_r <= 1'b0;
        end else begin
            cur_r <= cur_nxt;
            halfdb_r <= halfdb_nxt;
            muted_r <= muted_nxt;
        end
    end

    assign applied_code = cur_r;
    assign atten_halfdb = halfdb_r;
    assign muted = muted_r;

    chk_ramp_one_step: assert property (@(posedge clk) disable iff (reset)
        step_tick |=> (cur_r == $past(cur_r) || cur_r == $past(cur_r) + 8'h01
            || cur_r == $past(cur_r) - 8'h01))
        else $error("attenuator moved more than one step");
    chk_ramp_idle: assert property (@(posedge clk) disable iff (reset)
        !step_tick |=> $stable(cur_r))
        else $error("attenuator moved without a step tick");
    chk_mute_reach: assert property (@(posedge clk) disable iff (reset)
        (soft_mute && step_tick && cur_r == floor_code + 8'h01
            && $stable(atten_mode_sel)) |=> muted_r)
        else $error("soft mute did not reach full mute");
endmodule
`default_nettype wire

// [hdl/dmr_bank.sv]
/*
 dac mode register bank with serial control port and two attenuators.
 assumes port_serial_clock is quiet while port_select_n is high and that
 sample_rate_clk and the serial pins are asynchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none
module dmr_bank
    import dmr_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic port_select_n,
    input wire logic port_serial_clock,
    input wire logic port_serial_in,
    input wire logic sample_rate_clk,
    input wire dmr_clk_ratio_t clk_ratio,
    output logic [7:0] left_atten_code,
    output logic [7:0] right_atten_code,
    output logic [7:0] left_applied_code,
    output logic [7:0] right_applied_code,
    output logic [8:0] left_atten_halfdb,
    output logic [8:0] right_atten_halfdb,
    output logic left_muted,
    output logic right_muted,
    output logic left_soft_mute,
    output logic right_soft_mute,
    output logic oversample_boost,
    output dmr_os_rate_t os_rate,
    output logic soft_reset_busy,
    output logic left_output_disable,
    output logic right_output_disable,
    output logic deemph_enable,
    output logic [1:0] deemph_rate_sel,
    output logic [2:0] audio_format_sel,
    output logic filter_rolloff_sel,
    output logic atten_mode_sel,
    output logic output_phase_invert,
    output logic zero_flag_polarity,
    output logic zero_flag_common
);
    // link side: shift in on serial clock rising edges
    logic [WORD_BITS-1:0] shift_r, shift_nxt, word_r, word_nxt;
    logic [4:0] bits_r, bits_nxt;
    logic tgl_r, tgl_nxt;
    logic link_clr;

    assign link_clr = reset | port_select_n;

    always_comb begin
        shift_nxt = {shift_r[WORD_BITS-2:0], port_serial_in};
        bits_nxt = (bits_r == 5'd16) ? bits_r : bits_r + 5'd1;
        word_nxt = word_r;
        tgl_nxt = tgl_r;
        if (bits_r == 5'd15) begin
            word_nxt = shift_nxt;
            tgl_nxt = ~tgl_r;
        end
    end

    always_ff @(posedge port_serial_clock or posedge link_clr) begin
        if (link_clr) begin
            bits_r <= 5'd0;
        end else begin
            bits_r <= bits_nxt;
        end
    end

    always_ff @(posedge port_serial_clock or posedge reset) begin
        if (reset) begin
            shift_r <= 16'h0000;
            word_r <= 16'h0000;
            tgl_r <= 1'b0;
        end else begin
            shift_r <= shift_nxt;
            word_r <= word_nxt;
            tgl_r <= tgl_nxt;
        end
    end

    // system side synchronisers
    logic sel_meta_r, sel_sync_r, tgl_meta_r, tgl_sync_r, seen_r, seen_nxt;
    logic fs_meta_r, fs_sync_r, fs_prev_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            sel_meta_r <= 1'b1;
            sel_sync_r <= 1'b1;
            tgl_meta_r <= 1'b0;
            tgl_sync_r <= 1'b0;
            fs_meta_r <= 1'b0;
            fs_sync_r <= 1'b0;
            fs_prev_r <= 1'b0;
        end else begin
            sel_meta_r <= port_select_n;
            sel_sync_r <= sel_meta_r;
            tgl_meta_r <= tgl_r;
            tgl_sync_r <= tgl_meta_r;
            fs_meta_r <= sample_rate_clk;
            fs_sync_r <= fs_meta_r;
            fs_prev_r <= fs_sync_r;
        end
    end

    // commit once select is back high and a full word is waiting
    logic commit, busy, idx_ok;
    logic [6:0] idx;
    logic [7:0] data;

    assign commit = sel_sync_r && (tgl_sync_r != seen_r);
    assign idx = word_r[IDX_MSB:IDX_LSB];
    assign data = word_r[7:0];
    assign idx_ok = idx >= IDX_LEFT_ATTEN && idx <= IDX_PHASE_CTRL;

    always_comb begin
        seen_nxt = commit ? tgl_sync_r : seen_r;
    end

    // mode registers
    logic [7:0] left_r, left_nxt, right_r, right_nxt;
    logic lmute_r, lmute_nxt, rmute_r, rmute_nxt, boost_r, boost_nxt;
    logic ldis_r, ldis_nxt, rdis_r, rdis_nxt, dem_r, dem_nxt;
    logic [1:0] dem_rate_r, dem_rate_nxt;
    logic [2:0] fmt_r, fmt_nxt;
    logic roll_r, roll_nxt, step_mode_r, step_mode_nxt;
    logic flag_com_r, flag_com_nxt, flag_pol_r, flag_pol_nxt, phase_inv_r, phase_inv_nxt;
    logic [10:0] soft_cnt_r, soft_cnt_nxt;
    logic soft_rst_go;

    assign busy = soft_cnt_r != 11'h000;
    assign soft_rst_go = commit && !busy && idx == IDX_MUTE_CTRL && data[SOFT_RST_BIT];

    always_comb begin
        left_nxt = left_r;
        right_nxt = right_r;
        lmute_nxt = lmute_r;
        rmute_nxt = rmute_r;
        boost_nxt = boost_r;
        ldis_nxt = ldis_r;
        rdis_nxt = rdis_r;
        dem_nxt = dem_r;
        dem_rate_nxt = dem_rate_r;
        fmt_nxt = fmt_r;
        roll_nxt = roll_r;
        step_mode_nxt = step_mode_r;
        flag_com_nxt = flag_com_r;
        flag_pol_nxt = flag_pol_r;
        phase_inv_nxt = phase_inv_r;
        soft_cnt_nxt = busy ? soft_cnt_r - 11'h001 : soft_cnt_r;
        if (commit && !busy && idx_ok) begin
            if (idx == IDX_LEFT_ATTEN) begin
                left_nxt = data;
            end else if (idx == IDX_RIGHT_ATTEN) begin
                right_nxt = data;
            end else if (idx == IDX_MUTE_CTRL) begin
                boost_nxt = data[BOOST_BIT];
                rmute_nxt = data[RMUTE_BIT];
                lmute_nxt = data[LMUTE_BIT];
            end else if (idx == IDX_OUTPUT_CTRL) begin
                dem_rate_nxt = data[DEM_RATE_MSB:DEM_RATE_LSB];
                dem_nxt = data[DEEMPH_BIT];
                rdis_nxt = data[RDIS_BIT];
                ldis_nxt = data[LDIS_BIT];
            end else if (idx == IDX_FORMAT_CTRL) begin
                roll_nxt = data[ROLLOFF_BIT];
                fmt_nxt = data[FMT_MSB:FMT_LSB];
            end else if (idx == IDX_STEP_CTRL) begin
                step_mode_nxt = data[STEP_MODE_BIT];
            end else begin
                flag_com_nxt = data[FLAG_COM_BIT];
                flag_pol_nxt = data[FLAG_POL_BIT];
                phase_inv_nxt = data[PHASE_INV_BIT];
            end
        end
        if (soft_rst_go) begin
            soft_cnt_nxt = SOFT_RST_CYCLES;
        end
        if (soft_rst_go || busy) begin
            left_nxt = ATTEN_RST;
            right_nxt = ATTEN_RST;
            lmute_nxt = 1'b0;
            rmute_nxt = 1'b0;
            boost_nxt = 1'b0;
            ldis_nxt = 1'b0;
            rdis_nxt = 1'b0;
            dem_nxt = 1'b0;
            dem_rate_nxt = DEM_RATE_RST;
            fmt_nxt = FMT_RST;
            roll_nxt = 1'b0;
            step_mode_nxt = 1'b0;
            flag_com_nxt = 1'b0;
            flag_pol_nxt = 1'b0;
            phase_inv_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            seen_r <= 1'b0;
            left_r <= ATTEN_RST;
            right_r <= ATTEN_RST;
            lmute_r <= 1'b0;
            rmute_r <= 1'b0;
            boost_r <= 1'b0;
            ldis_r <= 1'b0;
            rdis_r <= 1'b0;
            dem_r <= 1'b0;
            dem_rate_r <= DEM_RATE_RST;
            fmt_r <= FMT_RST;
            roll_r <= 1'b0;
            step_mode_r <= 1'b0;
            flag_com_r <= 1'b0;
            flag_pol_r <= 1'b0;
            phase_inv_r <= 1'b0;
            soft_cnt_r <= 11'h000;
        end else begin
            seen_r <= seen_nxt;
            left_r <= left_nxt;
            right_r <= right_nxt;
            lmute_r <= lmute_nxt;
            rmute_r <= rmute_nxt;
            boost_r <= boost_nxt;
            ldis_r <= ldis_nxt;
            rdis_r <= rdis_nxt;
            dem_r <= dem_nxt;
            dem_rate_r <= dem_rate_nxt;
            fmt_r <= fmt_nxt;
            roll_r <= roll_nxt;
            step_mode_r <= step_mode_nxt;
            flag_com_r <= flag_com_nxt;
            flag_pol_r <= flag_pol_nxt;
            phase_inv_r <= phase_inv_nxt;
            soft_cnt_r <= soft_cnt_nxt;
        end
    end

    // step tick every eight sample periods, oversampling rate
    logic [2:0] fs_cnt_r, fs_cnt_nxt;
    logic step_r, step_nxt, fs_edge;
    dmr_os_rate_t os_r, os_nxt;

    assign fs_edge = fs_sync_r && !fs_prev_r;

    always_comb begin
        fs_cnt_nxt = fs_edge ? fs_cnt_r + 3'h1 : fs_cnt_r;
        step_nxt = fs_edge && fs_cnt_r == STEP_LAST;
        if (clk_ratio == DMR_RATIO_HIGH) begin
            os_nxt = boost_r ? DMR_OS128 : DMR_OS64;
        end else if (clk_ratio == DMR_RATIO_MID) begin
            os_nxt = boost_r ? DMR_OS64 : DMR_OS32;
        end else begin
            os_nxt = boost_r ? DMR_OS32 : DMR_OS16;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            fs_cnt_r <= 3'h0;
            step_r <= 1'b0;
            os_r <= DMR_OS16;
        end else begin
            fs_cnt_r <= fs_cnt_nxt;
            step_r <= step_nxt;
            os_r <= os_nxt;
        end
    end

    dmr_atten_ramp u_left (
        .clk(clk),
        .reset(reset),
        .step_tick(step_r),
        .atten_code(left_r),
        .soft_mute(lmute_r),
        .atten_mode_sel(step_mode_r),
        .applied_code(left_applied_code),
        .atten_halfdb(left_atten_halfdb),
        .muted(left_muted)
    );

    dmr_atten_ramp u_right (
        .clk(clk),
        .reset(reset),
        .step_tick(step_r),
        .atten_code(right_r),
        .soft_mute(rmute_r),
        .atten_mode_sel(step_mode_r),
        .applied_code(right_applied_code),
        .atten_halfdb(right_atten_halfdb),
        .muted(right_muted)
    );

    assign left_atten_code = left_r;
    assign right_atten_code = right_r;
    assign left_soft_mute = lmute_r;
    assign right_soft_mute = rmute_r;
    assign oversample_boost = boost_r;
    assign os_rate = os_r;
    assign soft_reset_busy = busy;
    assign left_output_disable = ldis_r;
    assign right_output_disable = rdis_r;
    assign deemph_enable = dem_r;
    assign deemph_rate_sel = dem_rate_r;
    assign audio_format_sel = fmt_r;
    assign filter_rolloff_sel = roll_r;
    assign atten_mode_sel = step_mode_r;
    assign output_phase_invert = phase_inv_r;
    assign zero_flag_polarity = flag_pol_r;
    assign zero_flag_common = flag_com_r;

    // helper: length of the soft reset period
    logic [11:0] busy_len_r;
    always_ff @(posedge clk) begin
        if (reset) begin
            busy_len_r <= 12'h000;
        end else begin
            busy_len_r <= busy ? busy_len_r + 12'h001 : 12'h000;
        end
    end

    chk_left_write: assert property (@(posedge clk) disable iff (reset)
        (commit && !busy && idx == IDX_LEFT_ATTEN) |=> left_r == $past(data))
        else $error("left attenuation write lost");
    chk_bad_index: assert property (@(posedge clk) disable iff (reset)
        (commit && !busy && !idx_ok) |=> $stable(left_r) && $stable(fmt_r)
            && $stable(phase_inv_r) && $stable(boost_r) && !busy)
        else $error("out of range index changed a register");
    chk_soft_rst_len: assert property (@(posedge clk) disable iff (reset)
        $fell(busy) |-> busy_len_r == {1'b0, SOFT_RST_CYCLES})
        else $error("soft reset period length wrong");
    chk_soft_rst_dflt: assert property (@(posedge clk) disable iff (reset)
        soft_rst_go |=> busy && left_r == ATTEN_RST && fmt_r == FMT_RST && !lmute_r)
        else $error("soft reset did not restore defaults");
    chk_reset_dflt: assert property (@(posedge clk)
        $past(reset) && !reset |-> left_r == ATTEN_RST && right_r == ATTEN_RST
            && fmt_r == FMT_RST && !step_mode_r)
        else $error("hard reset defaults wrong");
    chk_os_map: assert property (@(posedge clk) disable iff (reset)
        (!boost_r && clk_ratio == DMR_RATIO_HIGH) |=> os_r == DMR_OS64)
        else $error("oversampling rate wrong");
    chk_phase_write: assert property (@(posedge clk) disable iff (reset)
        (commit && !busy && idx == IDX_PHASE_CTRL) |=> phase_inv_r == $past(data[PHASE_INV_BIT])
            && flag_com_r == $past(data[FLAG_COM_BIT]))
        else $error("phase and flag write lost");
    chk_step_spacing: assert property (@(posedge clk) disable iff (reset)
        step_r |=> !step_r [*4])
        else $error("step ticks too close");

    cov_left_write: cover property (@(posedge clk) disable iff (reset)
        commit && idx == IDX_LEFT_ATTEN);
    cov_soft_reset: cover property (@(posedge clk) disable iff (reset) soft_rst_go);
    cov_mute_ramp: cover property (@(posedge clk) disable iff (reset)
        step_r && rmute_r && !right_muted);
endmodule
`default_nettype wire

// [pkg/dmr_pkg.sv]
/*
 constants and types for the dac mode register bank.
 assumes one system clock domain plus the serial control port clock.
*/
`default_nettype none
package dmr_pkg;
    localparam int WORD_BITS = 16;
    localparam int IDX_MSB = 14;
    localparam int IDX_LSB = 8;
    localparam logic [6:0] IDX_LEFT_ATTEN = 7'h10;
    localparam logic [6:0] IDX_RIGHT_ATTEN = 7'h11;
    localparam logic [6:0] IDX_MUTE_CTRL = 7'h12;
    localparam logic [6:0] IDX_OUTPUT_CTRL = 7'h13;
    localparam logic [6:0] IDX_FORMAT_CTRL = 7'h14;
    localparam logic [6:0] IDX_STEP_CTRL = 7'h15;
    localparam logic [6:0] IDX_PHASE_CTRL = 7'h16;
    localparam int SOFT_RST_BIT = 7;
    localparam int BOOST_BIT = 6;
    localparam int RMUTE_BIT = 1;
    localparam int LMUTE_BIT = 0;
    localparam int DEM_RATE_MSB = 6;
    localparam int DEM_RATE_LSB = 5;
    localparam int DEEMPH_BIT = 4;
    localparam int RDIS_BIT = 1;
    localparam int LDIS_BIT = 0;
    localparam int ROLLOFF_BIT = 5;
    localparam int FMT_MSB = 2;
    localparam int FMT_LSB = 0;
    localparam int STEP_MODE_BIT = 0;
    localparam int FLAG_COM_BIT = 2;
    localparam int FLAG_POL_BIT = 1;
    localparam int PHASE_INV_BIT = 0;
    localparam logic [7:0] ATTEN_RST = 8'hff;
    localparam logic [1:0] DEM_RATE_RST = 2'h0;
    localparam logic [2:0] FMT_RST = 3'h5;
    localparam logic [7:0] ATTEN_FLOOR_FINE = 8'h80;
    localparam logic [7:0] ATTEN_FLOOR_WIDE = 8'h9a;
    localparam logic [2:0] STEP_LAST = 3'h7;
    localparam logic [10:0] SOFT_RST_CYCLES = 11'h400;
    typedef enum logic [1:0] {DMR_OS16, DMR_OS32, DMR_OS64, DMR_OS128} dmr_os_rate_t;
    typedef enum logic [1:0] {DMR_RATIO_LOW, DMR_RATIO_MID, DMR_RATIO_HIGH} dmr_clk_ratio_t;
endpackage
`default_nettype wire

// [tb/dmr_bank_bench.sv]
/*
 self-checking bench for dmr_bank.
 assumes dmr_host_model as the serial port host and a 20 ns clk.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module dmr_bank_bench
    import dmr_pkg::*;
;
    logic clk = 1'b0, reset = 1'b1, start = 1'b0, sample_rate_clk = 1'b0, done;
    logic [15:0] word = 16'h0000;
    logic [4:0] nbits = 5'h10;
    dmr_clk_ratio_t clk_ratio = DMR_RATIO_LOW;
    dmr_os_rate_t os_rate;
    logic sel_n, sck, sdi, left_muted, right_muted, left_soft_mute, right_soft_mute;
    logic oversample_boost, soft_reset_busy, left_output_disable, right_output_disable;
    logic deemph_enable, filter_rolloff_sel, atten_mode_sel, output_phase_invert;
    logic zero_flag_polarity, zero_flag_common;
    logic [1:0] deemph_rate_sel;
    logic [2:0] audio_format_sel;
    logic [7:0] left_atten_code, right_atten_code, left_applied_code, right_applied_code;
    logic [7:0] prev;
    logic [8:0] left_atten_halfdb, right_atten_halfdb;
    int fail_count = 0, checks_done = 0, cyc = 0, busy_len = 0, sdiv = 0, n = 0;

    dmr_host_model host (.start(start), .word(word), .nbits(nbits), .port_select_n(sel_n),
        .port_serial_clock(sck), .port_serial_in(sdi), .done(done));
    dmr_bank DUT (.clk(clk), .reset(reset), .port_select_n(sel_n), .port_serial_clock(sck),
        .port_serial_in(sdi), .sample_rate_clk(sample_rate_clk), .clk_ratio(clk_ratio),
        .left_atten_code(left_atten_code), .right_atten_code(right_atten_code),
        .left_applied_code(left_applied_code), .right_applied_code(right_applied_code),
        .left_atten_halfdb(left_atten_halfdb), .right_atten_halfdb(right_atten_halfdb),
        .left_muted(left_muted), .right_muted(right_muted),
        .left_soft_mute(left_soft_mute), .right_soft_mute(right_soft_mute),
        .oversample_boost(oversample_boost), .os_rate(os_rate),
        .soft_reset_busy(soft_reset_busy), .left_output_disable(left_output_disable),
        .right_output_disable(right_output_disable), .deemph_enable(deemph_enable),
        .deemph_rate_sel(deemph_rate_sel), .audio_format_sel(audio_format_sel),
        .filter_rolloff_sel(filter_rolloff_sel), .atten_mode_sel(atten_mode_sel),
        .output_phase_invert(output_phase_invert), .zero_flag_polarity(zero_flag_polarity),
        .zero_flag_common(zero_flag_common));

    initial begin
        forever #10 clk = ~clk;
    end
    // sample clock of ten clk periods, so one step is 80 clk cycles
    always @(negedge clk) begin
        sdiv <= (sdiv == 4) ? 0 : sdiv + 1;
        if (sdiv == 4) sample_rate_clk <= ~sample_rate_clk;
        if (soft_reset_busy === 1'b1) busy_len <= busy_len + 1;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic wr(input logic [6:0] idx, input logic [7:0] d, input int bits = 16);
        @(negedge clk);
        word = {1'b0, idx, d};
        nbits = 5'(bits);
        start = 1'b1;
        wait (done === 1'b0);
        @(negedge clk);
        start = 1'b0;
        wait (done === 1'b1);
        repeat (8) @(negedge clk);
    endtask
    task automatic wait_lvl(input logic rt, input logic [7:0] t, input int lim);
        for (int i = 0; i < lim; i++) begin
            if ((rt ? right_applied_code : left_applied_code) === t) break;
            @(negedge clk);
        end
        `CHK(rt ? right_applied_code : left_applied_code, t)
        repeat (2) @(negedge clk);
    endtask
    task automatic os_loop(input int b);
        for (int r = 0; r < 3; r++) begin
            @(negedge clk);
            clk_ratio = dmr_clk_ratio_t'(2'(r));
            repeat (3) @(negedge clk);
            `CHK(os_rate, dmr_os_rate_t'(2'(r + b)))
        end
    endtask
    task automatic chk_defaults();
        `CHK({left_atten_code, right_atten_code}, 16'hffff)
        `CHK({left_soft_mute, right_soft_mute, oversample_boost}, 3'h0)
        `CHK({left_output_disable, right_output_disable, deemph_enable, deemph_rate_sel},
            5'h00)
        `CHK({filter_rolloff_sel, audio_format_sel}, 4'h5)
        `CHK(atten_mode_sel, 1'b0)
        `CHK({zero_flag_common, zero_flag_polarity, output_phase_invert}, 3'h0)
    endtask

    initial begin
        repeat (5) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        chk_defaults();
        `CHK({soft_reset_busy, left_muted, right_muted, left_applied_code}, 11'h0ff)
        os_loop(0);
        wr(IDX_OUTPUT_CTRL, 8'h53);
        `CHK({deemph_rate_sel, deemph_enable, right_output_disable, left_output_disable},
            5'h17)
        wr(IDX_FORMAT_CTRL, 8'h24);
        `CHK({filter_rolloff_sel, audio_format_sel}, 4'hc)
        wr(IDX_PHASE_CTRL, 8'h07);
        `CHK({zero_flag_common, zero_flag_polarity, output_phase_invert}, 3'h7)
        // foreign indices and a short frame change nothing
        wr(7'h17, 8'h00);
        wr(7'h0f, 8'h00);
        wr(IDX_LEFT_ATTEN, 8'h00, 15);
        `CHK({left_atten_code, audio_format_sel}, 11'h7fc)
        wr(IDX_LEFT_ATTEN, 8'hfc);
        `CHK({left_atten_code, right_atten_code}, 16'hfcff)
        prev = left_applied_code;
        for (int k = 0; k < 3; k++) begin
            n = 0;
            while (left_applied_code === prev && n < 200) begin
                @(negedge clk);
                n++;
            end
            `CHK(left_applied_code, prev - 8'h01)
            if (k > 0) `CHK(n, 80)
            prev = left_applied_code;
        end
        repeat (2) @(negedge clk);
        `CHK(left_atten_halfdb, 9'h003)
        wr(IDX_LEFT_ATTEN, 8'h00);
        wait_lvl(1'b0, 8'h81, 11000);
        `CHK({left_muted, left_atten_halfdb}, 10'h07e)
        wait_lvl(1'b0, 8'h80, 200);
        `CHK(left_muted, 1'b1)
        wr(IDX_STEP_CTRL, 8'h01);
        `CHK(atten_mode_sel, 1'b1)
        wait_lvl(1'b0, 8'h9a, 2500);
        `CHK(left_muted, 1'b1)
        wr(IDX_LEFT_ATTEN, 8'h9b);
        wait_lvl(1'b0, 8'h9b, 200);
        `CHK({left_muted, left_atten_halfdb}, 10'h0c8)
        wr(IDX_MUTE_CTRL, 8'h02);
        `CHK({right_soft_mute, left_soft_mute}, 2'h2)
        wait_lvl(1'b1, 8'h9a, 8500);
        `CHK({right_muted, right_atten_code}, 9'h1ff)
        `CHK(right_atten_halfdb, 9'h0ca)
        wr(IDX_MUTE_CTRL, 8'h00);
        wait_lvl(1'b1, 8'hff, 8500);
        wr(IDX_MUTE_CTRL, 8'h40);
        `CHK(oversample_boost, 1'b1)
        os_loop(1);
        busy_len = 0;
        wr(IDX_MUTE_CTRL, 8'h83);
        `CHK(soft_reset_busy, 1'b1)
        wr(IDX_RIGHT_ATTEN, 8'h10);
        for (int i = 0; i < 1100 && soft_reset_busy !== 1'b0; i++) @(negedge clk);
        `CHK(busy_len, 1024)
        chk_defaults();
        tally_and_finish();
    end
endmodule
`default_nettype wire

// [tb/dmr_host_model.sv]
/*
 host model driving the three-wire serial control port.
 assumes the bench raises start with word and nbits held until done rises.
*/
`timescale 1ns/10ps
`default_nettype none
module dmr_host_model (
    input wire logic start,
    input wire logic [15:0] word,
    input wire logic [4:0] nbits,
    output logic port_select_n,
    output logic port_serial_clock,
    output logic port_serial_in,
    output logic done
);
    initial begin
        port_select_n = 1'b1;
        port_serial_clock = 1'b0;
        port_serial_in = 1'b0;
        done = 1'b1;
    end
    // serial clock runs only inside a frame, 48 ns period
    always @(posedge start) begin
        done = 1'b0;
        port_select_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            port_serial_in = word[15 - i];
            #24 port_serial_clock = 1'b1;
            #24 port_serial_clock = 1'b0;
        end
        #24 port_select_n = 1'b1;
        port_serial_in = ~port_serial_in;
        done = 1'b1;
    end
endmodule
`default_nettype wire
